// [src/swire_defines.svh]
// Purpose: Timing counts and opcodes shared by both link ends
// Assumes: 250 MHz clock
// Notes:   Times are in ns; counts derive from the clock period
`ifndef SWIRE_DEFINES_SVH
`define SWIRE_DEFINES_SVH

`define SW_CLK_NS          4
`define SW_CW              17
// Least times round up, longest round down
`define SW_CYC_UP(t)       (((t) + `SW_CLK_NS - 1) / `SW_CLK_NS)
`define SW_CYC_DN(t)       ((t) / `SW_CLK_NS)

// ----------------------------------------------------------------
// Function command opcodes
// ----------------------------------------------------------------
`define SW_OP_READ         8'h69
`define SW_OP_WRITE        8'h6c
`define SW_OP_COPY         8'h48
`define SW_OP_RECALL       8'hb8
`define SW_OP_LOCK         8'h6a
`define SW_OP_SYNC         8'hd2
`define SW_LAST_ADDR       8'hff
`define SW_ONES            8'hff

// ----------------------------------------------------------------
// Device timing (standard / overdrive), ns
// ----------------------------------------------------------------
`define SW_RST_DET_STD_NS  120000
`define SW_RST_DET_OD_NS   40000
`define SW_PWAIT_STD_NS    15000
`define SW_PWAIT_OD_NS     2000
`define SW_PLOW_STD_NS     60000
`define SW_PLOW_OD_NS      8000
`define SW_SAMP_STD_NS     30000
`define SW_SAMP_OD_NS      3000
`define SW_HOLD_STD_NS     30000
`define SW_HOLD_OD_NS      3000

// ----------------------------------------------------------------
// Master timing (standard / overdrive), ns
// ----------------------------------------------------------------
`define SW_RSTL_STD_NS     480000
`define SW_RSTL_OD_NS      48000
`define SW_PSAMP_STD_NS    70000
`define SW_PSAMP_OD_NS     8500
`define SW_RSTH_STD_NS     410000
`define SW_RSTH_OD_NS      40000
`define SW_SLOT_STD_NS     65000
`define SW_SLOT_OD_NS      8000
`define SW_LOW0_STD_NS     60000
`define SW_LOW0_OD_NS      7500
`define SW_LOW1_STD_NS     6000
`define SW_LOW1_OD_NS      1000
`define SW_MSAMP_STD_NS    13000
`define SW_MSAMP_OD_NS     1500
`define SW_REC_STD_NS      5000
`define SW_REC_OD_NS       2000

`endif

// [src/swire_pkg.sv]
// Purpose: Types for both ends of the single-wire link
// Assumes: Nothing
// Notes:   Constants live in swire_defines.svh
package swire_pkg;

	typedef logic [16:0] cnt_t;

	typedef enum logic [1:0] {
		LK_IDLE  = 2'b00,
		LK_RSTLO = 2'b01,
		LK_PWAIT = 2'b10,
		LK_PLOW  = 2'b11
	} link_t;

	typedef enum logic [2:0] {
		P_OFF   = 3'b000,
		P_CMD   = 3'b001,
		P_ADDR  = 3'b010,
		P_WRITE = 3'b011,
		P_READ  = 3'b100,
		P_SYNC  = 3'b101,
		P_IDLE  = 3'b110
	} proto_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_RST  = 3'b001,
		M_PRES = 3'b010,
		M_SLOT = 3'b011,
		M_REC  = 3'b100
	} mphase_t;

endpackage

// [src/swire_if.sv]
// Purpose: Open-drain single-wire link between master and device
// Assumes: Passive pull-up; a pin pulls low only when enabled
// Notes:   Line level is the wired-AND of both ends
`timescale 1ns/1ps
interface swire_if;
	logic line;
	logic dev_oe;
	logic dev_out;
	logic mst_oe;
	logic mst_out;

	// Pull-up wins unless an enabled driver pulls low
	assign line = !((dev_oe && !dev_out) || (mst_oe && !mst_out));

	modport device (input line, output dev_oe, output dev_out);
	modport master (input line, output mst_oe, output mst_out);
endinterface

// [src/swire_dev.sv]
// Purpose: Device end of the single-wire link: slot timing and
//          function command decoding
// Assumes: Function command follows presence directly; the net
//          address stage is handled outside this block
// Notes:   Memory, EEPROM and measurement sit on the user side
`timescale 1ns/1ps
`include "swire_defines.svh"
module swire_dev
	import swire_pkg::*;
#(
	parameter int unsigned RST_DET_STD = `SW_CYC_DN(`SW_RST_DET_STD_NS),
	parameter int unsigned RST_DET_OD  = `SW_CYC_DN(`SW_RST_DET_OD_NS),
	parameter int unsigned PWAIT_STD   = `SW_CYC_UP(`SW_PWAIT_STD_NS),
	parameter int unsigned PWAIT_OD    = `SW_CYC_UP(`SW_PWAIT_OD_NS),
	parameter int unsigned PLOW_STD    = `SW_CYC_UP(`SW_PLOW_STD_NS),
	parameter int unsigned PLOW_OD     = `SW_CYC_UP(`SW_PLOW_OD_NS),
	parameter int unsigned SAMP_STD    = `SW_CYC_UP(`SW_SAMP_STD_NS),
	parameter int unsigned SAMP_OD     = `SW_CYC_UP(`SW_SAMP_OD_NS),
	parameter int unsigned HOLD_STD    = `SW_CYC_UP(`SW_HOLD_STD_NS),
	parameter int unsigned HOLD_OD     = `SW_CYC_UP(`SW_HOLD_OD_NS)
) (
	input  wire logic clk,
	input  wire logic rst_n,
	swire_if.device   bus,
	input  wire logic overdrive,
	input  wire logic ready,
	input  wire logic [7:0] rd_data,
	output logic      [7:0] rd_addr,
	output logic            wr_valid,
	output logic      [7:0] wr_addr,
	output logic      [7:0] wr_data,
	output logic            copy_req,
	output logic            recall_req,
	output logic            lock_req,
	output logic      [7:0] blk_addr,
	output logic            snapshot
);

	typedef struct packed {
		logic [2:0] sync;
		logic       lvl;
		logic       od;
		cnt_t       low_cnt;
		cnt_t       cnt;
		link_t      link;
		proto_t     proto;
		logic       in_slot;
		logic       drive_low;
		logic [2:0] bitn;
		logic [7:0] sh;
		logic [7:0] cmd;
		logic [7:0] addr;
		logic       over;
		logic       wr_valid;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic       copy;
		logic       recall;
		logic       lock;
		logic [7:0] blk;
		logic       snap;
	} st_t;

	st_t r;
	st_t n;

	function automatic cnt_t pick(input logic od, input cnt_t s,
		input cnt_t o);
		return od ? o : s;
	endfunction

	logic       lvl_new;
	logic       fell;
	logic       rose;
	logic       rx_take;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;
	cnt_t       t_rst;
	cnt_t       t_samp;
	cnt_t       t_hold;

	// ------------------------------------------------------------
	// Line filter and timing selection
	// ------------------------------------------------------------
	always_comb begin
		lvl_new = (r.sync[1] == r.sync[2]) ? r.sync[2] : r.lvl;
		fell    = r.lvl && !lvl_new;
		rose    = !r.lvl && lvl_new;
		t_rst   = pick(r.od, cnt_t'(RST_DET_STD), cnt_t'(RST_DET_OD));
		t_samp  = pick(r.od, cnt_t'(SAMP_STD), cnt_t'(SAMP_OD));
		t_hold  = pick(r.od, cnt_t'(HOLD_STD), cnt_t'(HOLD_OD));
		rx_byte = {lvl_new, r.sh[7:1]};
		tx_byte = r.over ? `SW_ONES : rd_data;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n          = r;
		n.sync     = {r.sync[1:0], bus.line};
		n.lvl      = lvl_new;
		n.wr_valid = 1'b0;
		n.copy     = 1'b0;
		n.recall   = 1'b0;
		n.lock     = 1'b0;
		n.snap     = 1'b0;
		rx_take    = 1'b0;

		if (!lvl_new && r.low_cnt != '1)
			n.low_cnt = r.low_cnt + 17'h1;
		else if (lvl_new)
			n.low_cnt = '0;

		case (r.link)
		LK_IDLE: begin
			if (r.in_slot) begin
				n.cnt = r.cnt + 17'h1;
				// Release before slot end, after valid time
				if (r.cnt == t_hold)
					n.drive_low = 1'b0;
				if (r.proto == P_SYNC && rose) begin
					n.snap  = 1'b1;
					n.proto = P_IDLE;
				end
				if (r.cnt == t_samp) begin
					n.in_slot = 1'b0;
					rx_take   = (r.proto != P_READ);
				end
			end else if (fell && r.proto != P_OFF) begin
				n.in_slot = 1'b1;
				n.cnt     = '0;
				if (r.proto == P_READ) begin
					n.bitn = r.bitn + 3'h1;
					if (r.bitn == 3'h0) begin
						n.drive_low = !tx_byte[0];
						n.sh        = {1'b0, tx_byte[7:1]};
					end else begin
						n.drive_low = !r.sh[0];
						n.sh        = {1'b0, r.sh[7:1]};
					end
					if (r.bitn == 3'h7) begin
						n.addr = r.addr + 8'h1;
						if (r.addr == `SW_LAST_ADDR)
							n.over = 1'b1;
					end
				end
			end
		end
		LK_RSTLO: begin
			if (rose) begin
				n.link = LK_PWAIT;
				n.cnt  = '0;
			end
		end
		LK_PWAIT: begin
			n.cnt = r.cnt + 17'h1;
			if (r.cnt == pick(r.od, cnt_t'(PWAIT_STD),
				cnt_t'(PWAIT_OD))) begin
				n.cnt = '0;
				// Silent when not ready: no presence, no commands
				if (ready) begin
					n.link      = LK_PLOW;
					n.drive_low = 1'b1;
				end else begin
					n.link = LK_IDLE;
				end
			end
		end
		LK_PLOW: begin
			n.cnt = r.cnt + 17'h1;
			if (r.cnt == pick(r.od, cnt_t'(PLOW_STD),
				cnt_t'(PLOW_OD))) begin
				n.drive_low = 1'b0;
				n.link      = LK_IDLE;
				n.proto     = P_CMD;
				n.bitn      = '0;
			end
		end
		default: n.link = LK_IDLE;
		endcase

		// ------------------------------------------------------------
		// Byte assembly and command decode, LSb first
		// ------------------------------------------------------------
		if (rx_take && r.proto != P_IDLE && r.proto != P_SYNC) begin
			n.sh   = rx_byte;
			n.bitn = r.bitn + 3'h1;
			if (r.bitn == 3'h7) begin
				case (r.proto)
				P_CMD: begin
					n.cmd = rx_byte;
					case (rx_byte)
					`SW_OP_READ, `SW_OP_WRITE, `SW_OP_COPY,
					`SW_OP_RECALL, `SW_OP_LOCK, `SW_OP_SYNC:
						n.proto = P_ADDR;
					default: n.proto = P_IDLE;
					endcase
				end
				P_ADDR: begin
					n.addr  = rx_byte;
					n.blk   = rx_byte;
					n.over  = 1'b0;
					n.proto = P_IDLE;
					case (r.cmd)
					`SW_OP_WRITE:  n.proto  = P_WRITE;
					`SW_OP_READ:   n.proto  = P_READ;
					`SW_OP_COPY:   n.copy   = 1'b1;
					`SW_OP_RECALL: n.recall = 1'b1;
					`SW_OP_LOCK:   n.lock   = 1'b1;
					`SW_OP_SYNC:   n.proto  = P_SYNC;
					default:       n.proto  = P_IDLE;
					endcase
				end
				P_WRITE: begin
					// Bytes past the last address are dropped
					if (!r.over) begin
						n.wr_valid = 1'b1;
						n.wr_addr  = r.addr;
						n.wr_data  = rx_byte;
						n.addr     = r.addr + 8'h1;
						if (r.addr == `SW_LAST_ADDR)
							n.over = 1'b1;
					end
				end
				default: n.proto = P_IDLE;
				endcase
			end
		end

		// Long low overrides everything but the presence low, even a slot in flight
		if (r.low_cnt == t_rst && !lvl_new && r.link != LK_PLOW) begin
			n.link      = LK_RSTLO;
			n.proto     = P_OFF;
			n.in_slot   = 1'b0;
			n.drive_low = 1'b0;
			n.bitn      = '0;
			n.od        = overdrive;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			r <= '0;
		else
			r <= n;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign bus.dev_out = 1'b0;
	assign bus.dev_oe  = r.drive_low;
	assign rd_addr     = r.addr;
	assign wr_valid    = r.wr_valid;
	assign wr_addr     = r.wr_addr;
	assign wr_data     = r.wr_data;
	assign copy_req    = r.copy;
	assign recall_req  = r.recall;
	assign lock_req    = r.lock;
	assign blk_addr    = r.blk;
	assign snapshot    = r.snap;

endmodule

// [src/swire_mst.sv]
// Purpose: Master end of the single-wire link: reset and bit slots
// Assumes: User issues one request at a time while not busy
// Notes:   A read is a write-one slot; bit_rx holds the sample
`timescale 1ns/1ps
`include "swire_defines.svh"
module swire_mst
	import swire_pkg::*;
#(
	parameter int unsigned RSTL_STD  = `SW_CYC_UP(`SW_RSTL_STD_NS),
	parameter int unsigned RSTL_OD   = `SW_CYC_UP(`SW_RSTL_OD_NS),
	parameter int unsigned PSAMP_STD = `SW_CYC_UP(`SW_PSAMP_STD_NS),
	parameter int unsigned PSAMP_OD  = `SW_CYC_UP(`SW_PSAMP_OD_NS),
	parameter int unsigned RSTH_STD  = `SW_CYC_UP(`SW_RSTH_STD_NS),
	parameter int unsigned RSTH_OD   = `SW_CYC_UP(`SW_RSTH_OD_NS),
	parameter int unsigned SLOT_STD  = `SW_CYC_UP(`SW_SLOT_STD_NS),
	parameter int unsigned SLOT_OD   = `SW_CYC_UP(`SW_SLOT_OD_NS),
	parameter int unsigned LOW0_STD  = `SW_CYC_UP(`SW_LOW0_STD_NS),
	parameter int unsigned LOW0_OD   = `SW_CYC_UP(`SW_LOW0_OD_NS),
	parameter int unsigned LOW1_STD  = `SW_CYC_UP(`SW_LOW1_STD_NS),
	parameter int unsigned LOW1_OD   = `SW_CYC_UP(`SW_LOW1_OD_NS),
	parameter int unsigned MSAMP_STD = `SW_CYC_DN(`SW_MSAMP_STD_NS),
	parameter int unsigned MSAMP_OD  = `SW_CYC_DN(`SW_MSAMP_OD_NS),
	parameter int unsigned REC_STD   = `SW_CYC_UP(`SW_REC_STD_NS),
	parameter int unsigned REC_OD    = `SW_CYC_UP(`SW_REC_OD_NS)
) (
	input  wire logic clk,
	input  wire logic rst_n,
	swire_if.master   bus,
	input  wire logic overdrive,
	input  wire logic reset_req,
	input  wire logic bit_req,
	input  wire logic bit_val,
	output logic      busy,
	output logic      done,
	output logic      presence,
	output logic      bit_rx
);

	typedef struct packed {
		logic [2:0] sync;
		logic       lvl;
		mphase_t    ph;
		cnt_t       cnt;
		logic       val;
		logic       pull;
		logic       done;
		logic       pres;
		logic       rx;
	} st_t;

	st_t r;
	st_t n;

	function automatic cnt_t pick(input logic od, input cnt_t s,
		input cnt_t o);
		return od ? o : s;
	endfunction

	cnt_t t_low;

	// ------------------------------------------------------------
	// Slot sequencer
	// ------------------------------------------------------------
	always_comb begin
		n      = r;
		n.sync = {r.sync[1:0], bus.line};
		if (r.sync[1] == r.sync[2])
			n.lvl = r.sync[2];
		n.done = 1'b0;
		n.cnt  = r.cnt + 17'h1;
		t_low  = r.val ? pick(overdrive, cnt_t'(LOW1_STD),
			cnt_t'(LOW1_OD)) : pick(overdrive, cnt_t'(LOW0_STD),
			cnt_t'(LOW0_OD));

		case (r.ph)
		M_IDLE: begin
			n.cnt = '0;
			if (reset_req) begin
				n.ph   = M_RST;
				n.pull = 1'b1;
			end else if (bit_req) begin
				n.ph   = M_SLOT;
				n.val  = bit_val;
				n.pull = 1'b1;
			end
		end
		M_RST: begin
			if (r.cnt == pick(overdrive, cnt_t'(RSTL_STD),
				cnt_t'(RSTL_OD))) begin
				n.pull = 1'b0;
				n.ph   = M_PRES;
				n.cnt  = '0;
			end
		end
		M_PRES: begin
			if (r.cnt == pick(overdrive, cnt_t'(PSAMP_STD),
				cnt_t'(PSAMP_OD)))
				n.pres = !r.lvl;
			if (r.cnt == pick(overdrive, cnt_t'(RSTH_STD),
				cnt_t'(RSTH_OD))) begin
				n.ph   = M_IDLE;
				n.done = 1'b1;
			end
		end
		M_SLOT: begin
			if (r.cnt == t_low)
				n.pull = 1'b0;
			// Late sample tolerates slow pull-up rise
			if (r.cnt == pick(overdrive, cnt_t'(MSAMP_STD),
				cnt_t'(MSAMP_OD)))
				n.rx = r.lvl;
			if (r.cnt == pick(overdrive, cnt_t'(SLOT_STD),
				cnt_t'(SLOT_OD))) begin
				n.pull = 1'b0;
				n.ph   = M_REC;
				n.cnt  = '0;
			end
		end
		M_REC: begin
			if (r.cnt == pick(overdrive, cnt_t'(REC_STD),
				cnt_t'(REC_OD))) begin
				n.ph   = M_IDLE;
				n.done = 1'b1;
			end
		end
		default: n.ph = M_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			r <= '0;
		else
			r <= n;
	end

	assign bus.mst_out = 1'b0;
	assign bus.mst_oe  = r.pull;
	assign busy        = (r.ph != M_IDLE);
	assign done        = r.done;
	assign presence    = r.pres;
	assign bit_rx      = r.rx;

endmodule

// [verification/swire_checker.sv]
// Purpose: Wire-level checks between the two link ends
// Assumes: Thresholds match the counts given to both ends
// Notes:   Lengths are counted in helper logic, not repetition
`timescale 1ns/1ps
module swire_checker #(
	parameter int unsigned RST_DET = 200,
	parameter int unsigned PWAIT   = 8,
	parameter int unsigned PLOW    = 30,
	parameter int unsigned HOLD    = 18,
	parameter int unsigned RSTL    = 300,
	parameter int unsigned LOW0    = 36,
	parameter int unsigned LOW1    = 6,
	parameter int unsigned SLOT    = 40,
	parameter int unsigned REC     = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic line,
	input wire logic dev_oe,
	input wire logic dev_out,
	input wire logic mst_oe,
	input wire logic mst_out
);
	logic [15:0] low_cnt, hi_cnt, last_low, dev_len, mst_len, since_mst;
	logic        line_q, dev_q, mst_q, pres_r;
	logic        pres_start, dev_fall, mst_rise, mst_fall;

	function automatic logic [15:0] inc(input logic [15:0] x);
		return (x == 16'hffff) ? x : x + 16'h1;
	endfunction

	assign pres_start = dev_oe && !dev_q && line_q;
	assign dev_fall   = !dev_oe && dev_q;
	assign mst_rise   = mst_oe && !mst_q;
	assign mst_fall   = !mst_oe && mst_q;

	// Saturated starts keep the first master request legal
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt   <= 16'h0;
			hi_cnt    <= 16'hffff;
			last_low  <= 16'h0;
			dev_len   <= 16'h0;
			mst_len   <= 16'h0;
			since_mst <= 16'hffff;
			line_q    <= 1'b1;
			dev_q     <= 1'b0;
			mst_q     <= 1'b0;
			pres_r    <= 1'b0;
		end else begin
			low_cnt   <= line ? 16'h0 : inc(low_cnt);
			hi_cnt    <= line ? inc(hi_cnt) : 16'h0;
			last_low  <= (line && !line_q) ? low_cnt : last_low;
			dev_len   <= dev_oe ? inc(dev_len) : 16'h0;
			mst_len   <= mst_oe ? inc(mst_len) : 16'h0;
			since_mst <= mst_rise ? 16'h1 : inc(since_mst);
			line_q    <= line;
			dev_q     <= dev_oe;
			mst_q     <= mst_oe;
			pres_r    <= pres_start | (dev_oe & pres_r);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	dev_open_drain_a: assert property (dev_out == 1'b0)
		else $error("device drives the line high");
	mst_open_drain_a: assert property (mst_out == 1'b0)
		else $error("master drives the line high");
	dev_fall_pres_a: assert property (pres_start |-> last_low >= RST_DET)
		else $error("device made a falling edge outside presence");
	pres_delay_a: assert property (pres_start |->
		hi_cnt >= PWAIT && hi_cnt <= PWAIT + 5)
		else $error("presence wait out of range");
	pres_width_a: assert property (dev_fall && pres_r |->
		dev_len >= PLOW - 1 && dev_len <= PLOW + 1)
		else $error("presence low width wrong");
	read_hold_a: assert property (dev_fall && !pres_r |->
		dev_len >= HOLD - 1 && dev_len <= HOLD + 1)
		else $error("read zero hold wrong");
	read_release_a: assert property (mst_rise |-> !dev_oe)
		else $error("device still low at next slot");
	long_low_quiet_a: assert property (low_cnt > RST_DET |-> !dev_oe)
		else $error("device drives during reset low");
	mst_low_len_a: assert property (mst_fall |->
		(mst_len >= LOW1 - 1 && mst_len <= LOW1 + 1) ||
		(mst_len >= LOW0 - 1 && mst_len <= LOW0 + 1) ||
		(mst_len >= RSTL - 1 && mst_len <= RSTL + 1))
		else $error("master low width wrong");
	slot_space_a: assert property (mst_rise |->
		hi_cnt >= REC && since_mst >= SLOT)
		else $error("slot spacing too short");

	cover property (pres_start);
	cover property (dev_fall && !pres_r);
	cover property (mst_fall && mst_len > SLOT);
endmodule

// [verification/tb_single_wire_slave_signaling.sv]
// Purpose: Drives both link ends through all function commands
// Assumes: Short counts so a run stays brief
// Notes:   Device pulses are matched in order against a queue
`timescale 1ns/1ps
`include "swire_defines.svh"
module tb_single_wire_slave_signaling;
	import swire_pkg::*;
	logic        clk, rst_n, ready, reset_req, bit_req, bit_val;
	logic        busy, done, presence, bit_rx, wr_valid, snapshot;
	logic        copy_req, recall_req, lock_req, d;
	logic [7:0]  rd_addr, rd_data, wr_addr, wr_data, blk_addr, a, v;
	logic [7:0]  mem [256];
	logic [7:0]  ops [3];
	logic [19:0] exp_q [$];
	logic [19:0] seen;
	logic        od;
	int          mismatches, compares, seed, i;

	// Shrunk counts keep a line reset near 500 cycles; both speeds share
	// them, so the speed input is a driven net rather than a tie-off
	localparam int unsigned T_RST_DET = 200;
	localparam int unsigned T_PWAIT   = 8;
	localparam int unsigned T_PLOW    = 30;
	localparam int unsigned T_SAMP    = 20;
	localparam int unsigned T_HOLD    = 18;
	localparam int unsigned T_RSTL    = 300;
	localparam int unsigned T_PSAMP   = 25;
	localparam int unsigned T_RSTH    = 200;
	localparam int unsigned T_SLOT    = 40;
	localparam int unsigned T_LOW0    = 36;
	localparam int unsigned T_LOW1    = 6;
	// Master filter lags the line by four cycles: sample well after LOW1
	localparam int unsigned T_MSAMP   = 14;
	localparam int unsigned T_REC     = 4;

	swire_if bus_if ();
	assign rd_data = mem[rd_addr];

	swire_dev #(.RST_DET_STD(T_RST_DET), .RST_DET_OD(T_RST_DET),
		.PWAIT_STD(T_PWAIT), .PWAIT_OD(T_PWAIT), .PLOW_STD(T_PLOW),
		.PLOW_OD(T_PLOW), .SAMP_STD(T_SAMP), .SAMP_OD(T_SAMP),
		.HOLD_STD(T_HOLD), .HOLD_OD(T_HOLD)) swire_dev_i (
		.clk(clk), .rst_n(rst_n), .bus(bus_if), .overdrive(od),
		.ready(ready), .rd_data(rd_data), .rd_addr(rd_addr),
		.wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
		.copy_req(copy_req), .recall_req(recall_req),
		.lock_req(lock_req), .blk_addr(blk_addr), .snapshot(snapshot));

	swire_mst #(.RSTL_STD(T_RSTL), .RSTL_OD(T_RSTL),
		.PSAMP_STD(T_PSAMP), .PSAMP_OD(T_PSAMP), .RSTH_STD(T_RSTH),
		.RSTH_OD(T_RSTH), .SLOT_STD(T_SLOT), .SLOT_OD(T_SLOT),
		.LOW0_STD(T_LOW0), .LOW0_OD(T_LOW0), .LOW1_STD(T_LOW1),
		.LOW1_OD(T_LOW1), .MSAMP_STD(T_MSAMP), .MSAMP_OD(T_MSAMP),
		.REC_STD(T_REC), .REC_OD(T_REC)) swire_mst_i (
		.clk(clk), .rst_n(rst_n), .bus(bus_if), .overdrive(od),
		.reset_req(reset_req), .bit_req(bit_req), .bit_val(bit_val),
		.busy(busy), .done(done), .presence(presence), .bit_rx(bit_rx));

	swire_checker #(.RST_DET(T_RST_DET), .PWAIT(T_PWAIT), .PLOW(T_PLOW),
		.HOLD(T_HOLD), .RSTL(T_RSTL), .LOW0(T_LOW0), .LOW1(T_LOW1),
		.SLOT(T_SLOT), .REC(T_REC)) swire_checker_i (
		.clk(clk), .rst_n(rst_n),
		.line(bus_if.line), .dev_oe(bus_if.dev_oe),
		.dev_out(bus_if.dev_out), .mst_oe(bus_if.mst_oe),
		.mst_out(bus_if.mst_out));

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [19:0] s,
		input logic [19:0] e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Bounded wait; a lost done ends the run at once
	task automatic wait_done();
		int n;
		for (n = 0; n < 3000 && done !== 1'b1; n++)
			@(negedge clk);
		if (done !== 1'b1) begin
			check("done", 20'h0, 20'h1);
			report_and_stop();
		end
	endtask

	task automatic line_reset(input logic p);
		@(posedge clk);
		reset_req <= 1'b1;
		@(posedge clk);
		reset_req <= 1'b0;
		wait_done();
		check("presence", {19'h0, presence}, {19'h0, p});
	endtask

	task automatic send_bit(input logic b, output logic r);
		@(posedge clk);
		bit_req <= 1'b1;
		bit_val <= b;
		@(posedge clk);
		bit_req <= 1'b0;
		wait_done();
		r = bit_rx;
	endtask

	task automatic send_byte(input logic [7:0] b);
		logic r;
		for (int k = 0; k < 8; k++)
			send_bit(b[k], r);
	endtask

	task automatic read_byte(output logic [7:0] b);
		for (int k = 0; k < 8; k++)
			send_bit(1'b1, b[k]);
	endtask

	// Any device pulse must match the oldest note
	always @(posedge clk) begin
		if (rst_n === 1'b1 && (wr_valid | copy_req | recall_req |
			lock_req | snapshot) === 1'b1) begin
			seen = wr_valid ? {4'h1, wr_addr, wr_data} :
				copy_req ? {4'h2, blk_addr, 8'h00} :
				recall_req ? {4'h3, blk_addr, 8'h00} :
				lock_req ? {4'h4, blk_addr, 8'h00} : {4'h5, 16'h0};
			if (exp_q.size() == 0)
				check("event", seen, 20'h0);
			else
				check("event", seen, exp_q.pop_front());
		end
	end

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		rst_n = 1'b0;
		od = 1'b0;
		ready = 1'b0;
		reset_req = 1'b0;
		bit_req = 1'b0;
		bit_val = 1'b0;
		mismatches = 0;
		compares = 0;
		seed = 32'ha850ffd1;
		ops = '{`SW_OP_COPY, `SW_OP_RECALL, `SW_OP_LOCK};
		for (i = 0; i < 256; i++)
			mem[i] = 8'($random(seed));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		line_reset(1'b0);
		ready <= 1'b1;
		line_reset(1'b1);
		$display("test presence done");
		// Third byte lands past the last address and must vanish
		send_byte(`SW_OP_WRITE);
		send_byte(8'hfe);
		for (i = 0; i < 3; i++) begin
			v = 8'($random(seed));
			if (i < 2)
				exp_q.push_back({4'h1, 8'(8'hfe + i), v});
			send_byte(v);
		end
		$display("test write done");
		for (i = 0; i < 3; i++) begin
			line_reset(1'b1);
			a = 8'($random(seed));
			exp_q.push_back({4'(i + 2), a, 8'h00});
			send_byte(ops[i]);
			send_byte(a);
			read_byte(v);
			check("idle", {12'h0, v}, 20'hff);
		end
		$display("test block commands done");
		line_reset(1'b1);
		send_byte(`SW_OP_READ);
		send_byte(8'hfe);
		for (i = 0; i < 3; i++) begin
			read_byte(v);
			check("read", {12'h0, v}, {12'h0, (i < 2) ?
				mem[8'(8'hfe + i)] : 8'hff});
		end
		$display("test read done");
		line_reset(1'b1);
		exp_q.push_back({4'h5, 16'h0});
		send_byte(`SW_OP_SYNC);
		send_byte(8'($random(seed)));
		send_bit(1'b0, d);
		send_bit(1'b1, d);
		$display("test sync done");
		// Partial byte cut by a reset must not be stored
		line_reset(1'b1);
		send_byte(`SW_OP_WRITE);
		send_byte(8'h10);
		for (i = 0; i < 4; i++)
			send_bit(1'b0, d);
		line_reset(1'b1);
		a = 8'($random(seed));
		v = 8'($random(seed));
		exp_q.push_back({4'h1, a, v});
		send_byte(`SW_OP_WRITE);
		send_byte(a);
		send_byte(v);
		repeat (50) @(posedge clk);
		check("queue", 20'(exp_q.size()), 20'h0);
		$display("test abort done");
		report_and_stop();
	end
endmodule
